// ==== design/eeprom_map.svh ====
// Functional notes
// RULE_01 - SDA moves only while SCL is low; changes with SCL high are start or stop.
// RULE_02 - Start is SDA falling with SCL high; nothing is answered before a start.
// RULE_03 - Stop is SDA rising with SCL high; it ends every transfer and returns to standby.
// RULE_04 - The master issues a stop only after the transmitter has released SDA.
// RULE_05 - After eight bits the transmitter releases SDA; the receiver pulls it low on the ninth.
// RULE_06 - Acknowledge own slave address after a start, and every byte received when writing.
// RULE_07 - Read: send eight bits, release, continue on acknowledge, stop sending on none.
// RULE_08 - After a read ends without acknowledge the master issues a stop.
// RULE_09 - Slave byte: four type bits, three select bits matching pins, then read/write bit.
// RULE_10 - On any mismatch give no acknowledge and return to standby.
// RULE_11 - Byte address comes from two address bytes or from the internal counter.
// RULE_12 - 128 pages of 32 bytes; page from byte 1 and bits 7..5; offset bits 4..0.
// RULE_13 - Byte write: slave byte, two address bytes, one data byte, each acknowledged.
// RULE_14 - A stop after the data byte starts the internal nonvolatile write.
// RULE_15 - During the write cycle inputs are ignored and SDA is left undriven.
// RULE_16 - Page write acknowledges up to 31 more data bytes, 32 in all.
// RULE_17 - While loading, the in-page offset steps by one and the page stays fixed.
// RULE_18 - A stop after page loading starts the write of the loaded page.
// RULE_19 - For page writes the master sends the page's first byte address.
// RULE_20 - With write protect high, writes to the upper quarter are blocked.
// RULE_21 - The write cycle is timed internally, about 5 ms, with no master action.
// RULE_22 - The master starts every transfer and drives SCL; the device is only a slave.
// RULE_23 - No acknowledge of the slave address while a write cycle runs.
// RULE_24 - Writing past a page's last byte wraps to that page's first byte.
// RULE_25 - Sample SDA on SCL rising edges; change own SDA only while SCL is low.
// RULE_26 - Protected upper quarter is addresses 0xC00 through 0xFFF.
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
`define MEM_ADDR_W 12
`define PAGE_BYTES 32
`define PROTECT_BASE 12'hc00
`define WRITE_CYCLE_NS 5000000
`define SYS_CLK_NS 8
`define WRITE_CYCLE_COUNT (`WRITE_CYCLE_NS / `SYS_CLK_NS)
`define DEV_TYPE_MSB 7
`define DEV_TYPE_LSB 4
`define DEV_SEL_MSB 3
`define DEV_SEL_LSB 1
`define DEV_RW_BIT 0
`define LAST_BIT 3'h7
`define STATIC_INPUTS 4
`endif

// ==== design/eeprom_pkg.sv ====
package eeprom_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_COMMIT,
        ST_WAIT
    } state_t;
    typedef enum logic [1:0] {
        RX_DEV,
        RX_ADDR_HI,
        RX_ADDR_LO,
        RX_DATA
    } rx_kind_t;
endpackage : eeprom_pkg

// ==== design/line_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface line_if;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_level;
    logic write_protect;
    logic [2:0] select;
    modport sampler(output scl_rise, output scl_fall, output start_seen, output stop_seen,
                    output sda_level, output write_protect, output select);
    modport core(input scl_rise, input scl_fall, input start_seen, input stop_seen,
                 input sda_level, input write_protect, input select);
endinterface : line_if
`default_nettype wire

// ==== design/line_sampler.sv ====
`timescale 1ns/1ps
`default_nettype none
module line_sampler #(
    parameter int STATIC_W = 4
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic scl_pin,
    input wire logic sda_in,
    input wire logic [STATIC_W-1:0] static_in,
    line_if.sampler lines
);
    logic [STATIC_W+1:0] sync1_reg;
    logic [STATIC_W+1:0] sync2_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    wire logic scl_now = sync2_reg[STATIC_W+1];
    wire logic sda_now = sync2_reg[STATIC_W];

    // First stage feeds only the second; edges are taken after the second
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            sync1_reg <= {scl_pin, sda_in, static_in};
            sync2_reg <= sync1_reg;
            scl_prev_reg <= scl_now;
            sda_prev_reg <= sda_now;
        end
    end

    assign lines.scl_rise = scl_now && !scl_prev_reg; // RULE_25
    assign lines.scl_fall = !scl_now && scl_prev_reg; // RULE_22
    assign lines.start_seen = scl_now && scl_prev_reg && sda_prev_reg && !sda_now; // RULE_01 RULE_02
    assign lines.stop_seen = scl_now && scl_prev_reg && !sda_prev_reg && sda_now; // RULE_01 RULE_03
    assign lines.sda_level = sda_now;
    assign lines.write_protect = sync2_reg[3];
    assign lines.select = sync2_reg[2:0];
endmodule : line_sampler
`default_nettype wire

// ==== design/eeprom_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"
module eeprom_slave #(
    parameter int ADDR_W = `MEM_ADDR_W,
    parameter int PAGE_BYTES = `PAGE_BYTES,
    // Type code value is arbitrary
    parameter logic [3:0] DEVICE_TYPE_CODE = 4'h5,
    parameter int WRITE_CYCLES = `WRITE_CYCLE_COUNT
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic scl_pin,
    input wire logic sda_in,
    input wire logic device_select_bit0,
    input wire logic device_select_bit1,
    input wire logic device_select_bit2,
    input wire logic write_protect,
    output logic sda_out,
    output logic sda_oe
);
    import eeprom_pkg::*;

    localparam int OFS_W = $clog2(PAGE_BYTES);
    localparam int PAGE_W = ADDR_W - OFS_W;

    line_if lines();

    line_sampler #(
        .STATIC_W(`STATIC_INPUTS)
    ) u_sampler (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .scl_pin(scl_pin),
        .sda_in(sda_in),
        .static_in({write_protect, device_select_bit2, device_select_bit1, device_select_bit0}),
        .lines(lines)
    );

    state_t state_reg;
    rx_kind_t kind_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_shift_reg;
    logic byte_done_reg;
    logic [7:0] addr_hi_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic tx_pending_reg;
    logic write_sel_reg;
    logic master_ack_reg;
    logic [PAGE_W-1:0] buf_page_reg;
    logic [PAGE_BYTES-1:0] buf_valid_reg;
    logic [OFS_W-1:0] commit_idx_reg;
    logic [31:0] timer_reg;
    logic sda_oe_reg;
    logic sda_out_reg;

    logic [7:0] mem [2**ADDR_W];
    logic [7:0] page_buf [PAGE_BYTES];

    wire logic [15:0] rx_addr_full = {addr_hi_reg, shift_reg};
    wire logic [ADDR_W-1:0] rx_addr = rx_addr_full[ADDR_W-1:0]; // RULE_11 RULE_12
    wire logic type_match = shift_reg[`DEV_TYPE_MSB:`DEV_TYPE_LSB] == DEVICE_TYPE_CODE;
    wire logic sel_match = shift_reg[`DEV_SEL_MSB:`DEV_SEL_LSB] == lines.select;
    wire logic dev_match = type_match && sel_match; // RULE_09
    wire logic rw_read = shift_reg[`DEV_RW_BIT];
    wire logic [OFS_W-1:0] addr_ofs = addr_reg[OFS_W-1:0];
    wire logic [OFS_W-1:0] ofs_step = OFS_W'(addr_ofs + 1'b1);
    wire logic [ADDR_W-1:0] page_wrap_addr = {addr_reg[ADDR_W-1:OFS_W], ofs_step}; // RULE_17 RULE_24
    wire logic [ADDR_W-1:0] read_next_addr = ADDR_W'(addr_reg + 1'b1);
    wire logic [7:0] rd_byte = mem[addr_reg];
    wire logic [ADDR_W-1:0] commit_addr = {buf_page_reg, commit_idx_reg};
    wire logic commit_blocked = lines.write_protect && (commit_addr >= `PROTECT_BASE); // RULE_20 RULE_26
    wire logic commit_we = (state_reg == ST_COMMIT) && buf_valid_reg[commit_idx_reg] && !commit_blocked;
    wire logic commit_last = commit_idx_reg == OFS_W'(PAGE_BYTES - 1);
    wire logic rx_byte_end = (state_reg == ST_RX) && lines.scl_fall && byte_done_reg;
    wire logic buf_we = rx_byte_end && (kind_reg == RX_DATA);
    wire logic bus_active = (state_reg != ST_COMMIT) && (state_reg != ST_WAIT);
    wire logic commit_pending = write_sel_reg && (|buf_valid_reg);

    // Array and page buffer carry no reset; their contents are nonvolatile by intent
    always_ff @(posedge sys_clk) begin
        if (commit_we) begin
            mem[commit_addr] <= page_buf[commit_idx_reg];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (buf_we) begin
            page_buf[addr_ofs] <= shift_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            kind_reg <= RX_DEV;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            tx_shift_reg <= 8'h00;
            byte_done_reg <= 1'b0;
            addr_hi_reg <= 8'h00;
            addr_reg <= '0;
            tx_pending_reg <= 1'b0;
            write_sel_reg <= 1'b0;
            master_ack_reg <= 1'b0;
            buf_page_reg <= '0;
            buf_valid_reg <= '0;
            commit_idx_reg <= '0;
            timer_reg <= 32'h0;
            sda_oe_reg <= 1'b0;
        end else if (bus_active && lines.stop_seen) begin
            sda_oe_reg <= 1'b0; // RULE_03
            if (commit_pending) begin
                state_reg <= ST_COMMIT; // RULE_14 RULE_18
                commit_idx_reg <= '0;
            end else begin
                state_reg <= ST_IDLE;
                write_sel_reg <= 1'b0;
            end
        end else if (bus_active && lines.start_seen) begin
            state_reg <= ST_RX; // RULE_02
            kind_reg <= RX_DEV;
            bit_cnt_reg <= 3'h0;
            byte_done_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            tx_pending_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    sda_oe_reg <= 1'b0;
                end
                ST_RX: begin
                    if (lines.scl_rise && !byte_done_reg) begin
                        shift_reg <= {shift_reg[6:0], lines.sda_level}; // RULE_25
                        bit_cnt_reg <= 3'(bit_cnt_reg + 1'b1);
                        byte_done_reg <= (bit_cnt_reg == `LAST_BIT);
                    end else if (rx_byte_end) begin
                        byte_done_reg <= 1'b0;
                        bit_cnt_reg <= 3'h0;
                        state_reg <= ST_ACK;
                        sda_oe_reg <= 1'b1; // RULE_05 RULE_06
                        case (kind_reg)
                            RX_DEV: begin
                                if (!dev_match) begin
                                    state_reg <= ST_IDLE; // RULE_10
                                    sda_oe_reg <= 1'b0;
                                end else begin
                                    tx_pending_reg <= rw_read; // RULE_07
                                    write_sel_reg <= !rw_read;
                                    kind_reg <= RX_ADDR_HI;
                                end
                            end
                            RX_ADDR_HI: begin
                                addr_hi_reg <= shift_reg;
                                kind_reg <= RX_ADDR_LO;
                            end
                            RX_ADDR_LO: begin
                                addr_reg <= rx_addr; // RULE_11 RULE_13
                                buf_page_reg <= rx_addr[ADDR_W-1:OFS_W]; // RULE_12 RULE_19
                                buf_valid_reg <= '0;
                                kind_reg <= RX_DATA;
                            end
                            default: begin
                                buf_valid_reg[addr_ofs] <= 1'b1; // RULE_13 RULE_16
                                addr_reg <= page_wrap_addr; // RULE_17 RULE_24
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (lines.scl_fall) begin
                        if (tx_pending_reg) begin
                            tx_pending_reg <= 1'b0;
                            tx_shift_reg <= rd_byte;
                            sda_oe_reg <= !rd_byte[7];
                            addr_reg <= read_next_addr;
                            state_reg <= ST_TX;
                        end else begin
                            sda_oe_reg <= 1'b0; // RULE_05
                            state_reg <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (lines.scl_fall) begin
                        if (bit_cnt_reg == `LAST_BIT) begin
                            sda_oe_reg <= 1'b0; // RULE_05 RULE_07
                            bit_cnt_reg <= 3'h0;
                            state_reg <= ST_TX_ACK;
                        end else begin
                            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                            sda_oe_reg <= !tx_shift_reg[6]; // RULE_25
                            bit_cnt_reg <= 3'(bit_cnt_reg + 1'b1);
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (lines.scl_rise) begin
                        master_ack_reg <= !lines.sda_level;
                    end else if (lines.scl_fall) begin
                        if (master_ack_reg) begin
                            tx_shift_reg <= rd_byte; // RULE_07
                            sda_oe_reg <= !rd_byte[7];
                            addr_reg <= read_next_addr;
                            state_reg <= ST_TX;
                        end else begin
                            // Wait for the master's stop with SDA released
                            state_reg <= ST_IDLE; // RULE_07 RULE_08
                        end
                    end
                end
                ST_COMMIT: begin
                    sda_oe_reg <= 1'b0; // RULE_15
                    commit_idx_reg <= OFS_W'(commit_idx_reg + 1'b1);
                    if (commit_last) begin
                        state_reg <= ST_WAIT;
                        timer_reg <= 32'(WRITE_CYCLES - PAGE_BYTES); // RULE_21
                    end
                end
                ST_WAIT: begin
                    // Start and address are ignored here, so polling sees no acknowledge
                    sda_oe_reg <= 1'b0; // RULE_15 RULE_23
                    if (timer_reg == 32'h0) begin
                        state_reg <= ST_IDLE; // RULE_21 RULE_23
                        buf_valid_reg <= '0;
                        write_sel_reg <= 1'b0;
                    end else begin
                        timer_reg <= 32'(timer_reg - 1'b1);
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Open drain: the data line only ever pulls low
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_out_reg <= 1'b0;
        end else begin
            sda_out_reg <= 1'b0;
        end
    end

    assign sda_oe = sda_oe_reg;
    assign sda_out = sda_out_reg;
endmodule : eeprom_slave
`default_nettype wire

// ==== verification/eeprom_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module eeprom_chk #(
    parameter logic [3:0] DEVICE_TYPE_CODE = 4'h5
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic scl_pin,
    input wire logic sda_in,
    input wire logic device_select_bit0,
    input wire logic device_select_bit1,
    input wire logic device_select_bit2,
    input wire logic write_protect,
    input wire logic sda_out,
    input wire logic sda_oe
);
    import eeprom_pkg::*;
    logic scl_reg;
    logic sda_reg;
    logic started_reg;
    logic [7:0] shift_reg;
    logic [3:0] bits_reg;
    wire logic start_now = scl_pin && scl_reg && sda_reg && !sda_in;
    wire logic scl_up = scl_pin && !scl_reg;
    wire logic [2:0] pins = {device_select_bit2, device_select_bit1, device_select_bit0};
    wire logic addr_bad = bits_reg == 4'h8 && (shift_reg[7:4] != DEVICE_TYPE_CODE || shift_reg[3:1] != pins);
    // Bit count saturates so long reads never wrap back into the address byte window
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            started_reg <= 1'b0;
            shift_reg <= 8'h00;
            bits_reg <= 4'hf;
        end else begin
            scl_reg <= scl_pin;
            sda_reg <= sda_in;
            started_reg <= started_reg | start_now;
            if (start_now) bits_reg <= 4'h0;
            else if (scl_up && bits_reg != 4'hf) bits_reg <= bits_reg + 4'h1;
            if (scl_up) shift_reg <= {shift_reg[6:0], sda_in};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence scl_pulse;
        ##[1:40] $rose(scl_pin) ##[1:40] $fell(scl_pin);
    endsequence
    sda_out_zero_a: assert property (sda_out == 1'b0)
        else $error("sda_out not held low");
    reset_quiet_a: assert property (disable iff (1'b0) !reset_n |-> !sda_oe)
        else $error("sda driven during reset");
    oe_moves_low_a: assert property ($changed(sda_oe) |-> !scl_pin && $past(scl_pin, 8))
        else $error("sda output changed away from scl low phase");
    oe_holds_high_a: assert property ($rose(sda_oe) |-> sda_oe throughout scl_pulse)
        else $error("sda pull released before scl fall");
    stop_quiet_a: assert property (scl_pin && $past(scl_pin) && $rose(sda_in) |-> ##1 !sda_oe [*8])
        else $error("sda driven after stop");
    addr_nack_a: assert property (addr_bad |-> !sda_oe)
        else $error("foreign slave byte acknowledged");
    slave_byte_quiet_a: assert property (bits_reg < 4'h8 |-> !sda_oe)
        else $error("sda driven inside slave byte");
    no_start_quiet_a: assert property (!started_reg |-> !sda_oe)
        else $error("sda driven before any start");
endmodule : eeprom_chk
bind eeprom_slave eeprom_chk #(.DEVICE_TYPE_CODE(DEVICE_TYPE_CODE)) u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .scl_pin(scl_pin), .sda_in(sda_in), .device_select_bit0(device_select_bit0),
    .device_select_bit1(device_select_bit1), .device_select_bit2(device_select_bit2),
    .write_protect(write_protect), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ==== verification/bus_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    output logic scl,
    output logic pull_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    // 96 ns low, 64 ns high: the slave answers some 24 ns after the fall
    task automatic bit_cell(input logic drive_low, output logic seen);
        scl = 1'b0;
        #16 pull_low = drive_low;
        #80 scl = 1'b1;
        #32 seen = sda;
        #32;
    endtask : bit_cell
    task automatic start_c;
        scl = 1'b0;
        #16 pull_low = 1'b0;
        #80 scl = 1'b1;
        #64 pull_low = 1'b1;
        #64;
    endtask : start_c
    task automatic stop_c;
        scl = 1'b0;
        #16 pull_low = 1'b1;
        #80 scl = 1'b1;
        #64 pull_low = 1'b0;
        #64;
    endtask : stop_c
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cell(!b[i], s);
        bit_cell(1'b0, s);
        ack = !s;
    endtask : send
    task automatic recv(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cell(1'b0, b[i]);
        bit_cell(give_ack, s);
    endtask : recv
endmodule : bus_master_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import eeprom_pkg::*;
    // Type code value is arbitrary
    localparam logic [3:0] TYPE_CODE = 4'h9;
    // Short write cycle keeps the run brief, yet long enough that the first poll is refused
    localparam int WCYC = 1000;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b1;
    logic wp = 1'b0;
    logic [2:0] sel = 3'h5;
    logic scl;
    logic pull_low;
    logic sda_out;
    logic sda_oe;
    wire logic sda = !(sda_oe | pull_low);
    logic [7:0] rd_buf [32];
    int mismatches = 0;
    int n_compared = 0;
    always #4 sys_clk = ~sys_clk;
    eeprom_slave #(.DEVICE_TYPE_CODE(TYPE_CODE), .WRITE_CYCLES(WCYC)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .scl_pin(scl), .sda_in(sda), .device_select_bit0(sel[0]), .device_select_bit1(sel[1]),
        .device_select_bit2(sel[2]), .write_protect(wp), .sda_out(sda_out), .sda_oe(sda_oe));
    bus_master_model m (.scl(scl), .pull_low(pull_low), .sda(sda));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic set_pins(input logic [2:0] s, input logic w);
        @(posedge sys_clk);
        #1 sel = s;
        wp = w;
    endtask : set_pins
    task automatic set_addr(input logic [11:0] addr);
        logic a;
        m.start_c();
        m.send({TYPE_CODE, sel, 1'b0}, a);
        check("slave ack", a, 1'b1);
        m.send({4'h0, addr[11:8]}, a);
        check("hi ack", a, 1'b1);
        m.send(addr[7:0], a);
        check("lo ack", a, 1'b1);
    endtask : set_addr
    // Acknowledge polling, bounded so a stuck write cycle cannot hang the run
    task automatic wait_ready(output int polls);
        logic a;
        polls = 0;
        a = 1'b0;
        while (!a && polls < 40) begin
            m.start_c();
            m.send({TYPE_CODE, sel, 1'b0}, a);
            m.stop_c();
            polls++;
        end
        check("write cycle ends", a, 1'b1);
    endtask : wait_ready
    task automatic wr1(input logic [11:0] addr, input logic [7:0] d, output int polls);
        logic a;
        set_addr(addr);
        m.send(d, a);
        check("data ack", a, 1'b1);
        m.stop_c();
        wait_ready(polls);
    endtask : wr1
    task automatic read_at(input logic [11:0] addr, input int n);
        logic a;
        set_addr(addr);
        m.start_c();
        m.send({TYPE_CODE, sel, 1'b1}, a);
        check("read ack", a, 1'b1);
        for (int i = 0; i < n; i++) m.recv(i < n - 1, rd_buf[i]);
        m.stop_c();
    endtask : read_at
    task automatic s_select;
        logic a;
        m.send({TYPE_CODE, sel, 1'b0}, a);
        check("no start", a, 1'b0);
        m.stop_c();
        for (int k = 0; k < 16; k++) begin
            set_pins(k[3] ? 3'h2 : 3'h5, 1'b0);
            m.start_c();
            m.send({TYPE_CODE, k[2:0], 1'b0}, a);
            check("select", a, k[2:0] == sel);
            m.stop_c();
        end
        m.start_c();
        m.send({~TYPE_CODE, sel, 1'b0}, a);
        check("type", a, 1'b0);
        m.stop_c();
    endtask : s_select
    task automatic s_byte_write;
        int p;
        wr1(12'h012, 8'ha5, p);
        check("busy refuses", p > 1, 1'b1);
        read_at(12'h012, 1);
        check("byte", rd_buf[0], 8'ha5);
    endtask : s_byte_write
    task automatic s_page;
        logic a;
        int p;
        set_addr(12'h080);
        for (int k = 0; k < 32; k++) begin
            m.send(8'(k) ^ 8'h3c, a);
            check("page ack", a, 1'b1);
        end
        m.stop_c();
        wait_ready(p);
        // A full page leaves the counter wrapped to the page's first byte
        m.start_c();
        m.send({TYPE_CODE, sel, 1'b1}, a);
        check("current read ack", a, 1'b1);
        m.recv(1'b0, rd_buf[0]);
        m.stop_c();
        check("page wrap", rd_buf[0], 8'h3c);
        read_at(12'h080, 32);
        for (int o = 0; o < 32; o++) check("page data", rd_buf[o], 8'(o) ^ 8'h3c);
    endtask : s_page
    task automatic s_protect;
        int p;
        wr1(12'hc00, 8'h22, p);
        set_pins(sel, 1'b1);
        wr1(12'hc00, 8'h11, p);
        wr1(12'hbff, 8'h77, p);
        read_at(12'hbff, 2);
        check("below guard", rd_buf[0], 8'h77);
        check("guarded", rd_buf[1], 8'h22);
        set_pins(sel, 1'b0);
    endtask : s_protect
    initial begin
        // Reset falls after time zero so the asynchronous branch sees a real edge
        #1 reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        // Keep every pin change one step clear of the sampling edge
        #1;
        s_select();
        s_byte_write();
        s_page();
        s_protect();
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
